//--- inc/sensor_status_pkg.sv
// Types shared by the status and event routing block.
// Assumes nothing of its surroundings.
package sensor_status_pkg;
  typedef logic [1:0] chan_idx_t;
  typedef logic [3:0] chan_vec_t;
  typedef enum logic [1:0] {
    SCAN_SINGLE = 2'b01,
    SCAN_SEQ = 2'b10
  } scan_mode_t;
endpackage : sensor_status_pkg

//--- inc/sensor_status_regs.svh
// Register offsets, field positions and reset values of the status and event routing block.
// Assumes the serial register front end presents one decoded word access per cycle.
//
// Functional notes
// [R1] Two-bit source field names channel of the latched flag; code 00 is ch0, 11 ch3.
// [R2] A flagged error stays latched until status or source channel result is read.
// [R3] Watchdog status bit sets when an active channel times out.
// [R4] Error and warning bits show only events since the last status read.
// [R5] Amplitude-high status bit sets when any active channel warns high.
// [R6] Amplitude-low status bit sets when any active channel warns low.
// [R7] Result-ready sets per conversion, or once all active channels converted in scan mode.
// [R8] One pending-result bit per channel, bit 3 for ch0 down to bit 0 for ch3.
// [R9] Watchdog-to-result enable puts timeouts in the channel result watchdog field.
// [R10] Amp-high-to-result enable puts high warnings in the channel result amplitude field.
// [R11] Amp-low-to-result enable puts low warnings in the channel result amplitude field.
// [R12] Watchdog-to-irq enable gates interrupt pin and watchdog status bit.
// [R13] Result-ready-to-irq enable gates interrupt pin and result-ready status bit.
// [R14] Host writes zeros to reserved routing bits 10:6.
// [R15] Interrupt pin asserts on status update unless the pin-disable bit is set; amplitude flag updates do not assert it.
// [R16] Scan enable follows the channel sequence, else converts the single selected channel.
// [R17] Result read clears pending bit; status read releases the interrupt pin.
`ifndef SENSOR_STATUS_REGS_SVH
`define SENSOR_STATUS_REGS_SVH

// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define OFS_EVENT_STATUS 8'h18
`define OFS_EVENT_ROUTING 8'h19
`define OFS_RESULT_CH0 8'h00
`define OFS_RESULT_CH1 8'h02
`define OFS_RESULT_CH2 8'h04
`define OFS_RESULT_CH3 8'h06

// ---------------------------------------------------------------
// Status fields
// ---------------------------------------------------------------
`define ST_SRC_HI 15
`define ST_SRC_LO 14
`define ST_WD_BIT 11
`define ST_AH_BIT 10
`define ST_AL_BIT 9
`define ST_RDY_BIT 6

// ---------------------------------------------------------------
// Routing fields and reset values
// ---------------------------------------------------------------
`define RT_WD_OUT_BIT 13
`define RT_AH_OUT_BIT 12
`define RT_AL_OUT_BIT 11
`define RT_WD_IRQ_BIT 5
`define RT_RDY_IRQ_BIT 0
`define RT_WRITE_MASK 16'h3821
`define RT_RESET 16'h0000
`define ST_RESET 16'h0000

`endif

//--- src/chan_event_tracker.sv
// Per-channel pending-result flag and result register event fields.
// Assumes single-cycle event and read strobes from the conversion and register logic.
`timescale 1ns/1ps
`default_nettype none
module chan_event_tracker (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Events
  input wire logic active_i,
  input wire logic conv_done_i,
  input wire logic wd_i,
  input wire logic ah_i,
  input wire logic al_i,
  // Routing
  input wire logic wd_en_i,
  input wire logic ah_en_i,
  input wire logic al_en_i,
  // Host read
  input wire logic data_read_i,
  // Results
  output logic pending_o,
  output logic wd_field_o,
  output logic amp_field_o
);

  // ---------------------------------------------------------------
  // Pending result, new result beats a same-cycle read
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending_o <= 1'b0;
    end else begin
      pending_o <= (conv_done_i & active_i) | (pending_o & ~data_read_i); // [R8] [R17]
    end
  end

  // ---------------------------------------------------------------
  // Result register fields
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wd_field_o <= 1'b0;
    end else begin
      wd_field_o <= (wd_i & active_i & wd_en_i) | (wd_field_o & ~data_read_i); // [R9]
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      amp_field_o <= 1'b0;
    end else begin
      amp_field_o <= (((ah_i & ah_en_i) | (al_i & al_en_i)) & active_i) // [R10] [R11]
                     | (amp_field_o & ~data_read_i);
    end
  end

endmodule : chan_event_tracker
`default_nettype wire

//--- src/sensor_status_error_reporting.sv
// Status, event routing and interrupt pin logic of the four-channel converter.
// Assumes a register front end giving decoded one-cycle read and write strobes,
// and conversion engine events as one-cycle pulses per channel.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_status_regs.svh"
module sensor_status_error_reporting
  import sensor_status_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Conversion engine events
  input wire logic [3:0] conv_done_i,
  input wire logic [3:0] wd_timeout_i,
  input wire logic [3:0] amp_high_i,
  input wire logic [3:0] amp_low_i,
  // Configuration bits
  input wire logic sequence_scan_enable_i,
  input wire logic [1:0] active_chan_i,
  input wire logic [3:0] scan_chan_mask_i,
  input wire logic irq_pin_disable_i,
  // Result register fields
  output logic [3:0] result_watchdog_field_o,
  output logic [3:0] result_amplitude_field_o,
  // Pin
  output logic irq_pin_n_o
);

  // ---------------------------------------------------------------
  // Register file state
  // ---------------------------------------------------------------
  logic [15:0] event_routing_config_r;
  chan_idx_t fault_source_channel_r;
  logic watchdog_timeout_flag_r;
  logic amplitude_high_flag_r;
  logic amplitude_low_flag_r;
  logic result_ready_flag_r;
  logic irq_pend_r;
  logic irq_pend_nxt;
  chan_vec_t seen_r;
  chan_vec_t pending_vec;
  scan_mode_t mode_r;

  logic watchdog_to_result_en;
  logic amp_high_to_result_en;
  logic amp_low_to_result_en;
  logic watchdog_to_irq_en;
  logic result_ready_to_irq_en;

  assign watchdog_to_result_en = event_routing_config_r[`RT_WD_OUT_BIT];
  assign amp_high_to_result_en = event_routing_config_r[`RT_AH_OUT_BIT];
  assign amp_low_to_result_en = event_routing_config_r[`RT_AL_OUT_BIT];
  assign watchdog_to_irq_en = event_routing_config_r[`RT_WD_IRQ_BIT];
  assign result_ready_to_irq_en = event_routing_config_r[`RT_RDY_IRQ_BIT];

  // ---------------------------------------------------------------
  // Access decode
  // ---------------------------------------------------------------
  logic status_rd;
  chan_vec_t data_rd;
  assign status_rd = reg_rd_i && (reg_addr_i == `OFS_EVENT_STATUS);
  assign data_rd = {reg_rd_i && (reg_addr_i == `OFS_RESULT_CH3),
                    reg_rd_i && (reg_addr_i == `OFS_RESULT_CH2),
                    reg_rd_i && (reg_addr_i == `OFS_RESULT_CH1),
                    reg_rd_i && (reg_addr_i == `OFS_RESULT_CH0)};

  // Routing register; reserved bits never store, so a careless host cannot set them
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_routing_config_r <= `RT_RESET;
    end else if (reg_wr_i && (reg_addr_i == `OFS_EVENT_ROUTING)) begin
      event_routing_config_r <= reg_wdata_i & `RT_WRITE_MASK; // [R14]
    end
  end

  // ---------------------------------------------------------------
  // Active channel set
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_r <= SCAN_SINGLE;
    end else begin
      mode_r <= sequence_scan_enable_i ? SCAN_SEQ : SCAN_SINGLE; // [R16]
    end
  end

  chan_vec_t act;
  always_comb begin
    unique case (mode_r)
      SCAN_SEQ: act = scan_chan_mask_i; // [R16]
      SCAN_SINGLE: act = chan_vec_t'(4'h1 << active_chan_i); // [R16]
      default: act = 4'h0;
    endcase
  end

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  chan_vec_t wd_ev;
  chan_vec_t ah_ev;
  chan_vec_t al_ev;
  chan_vec_t flagged;
  chan_vec_t seen_nxt;
  logic rdy_ev;
  logic err_latched;
  logic err_clear;
  chan_idx_t first_src;

  assign wd_ev = wd_timeout_i & act & {4{watchdog_to_irq_en}}; // [R12] [R3]
  assign ah_ev = amp_high_i & act; // [R5]
  assign al_ev = amp_low_i & act; // [R6]
  assign flagged = wd_ev | ah_ev | al_ev;
  assign err_latched = watchdog_timeout_flag_r | amplitude_high_flag_r | amplitude_low_flag_r;
  assign err_clear = status_rd | data_rd[fault_source_channel_r]; // [R2] [R4]

  // Lowest numbered channel wins when several flag at once
  always_comb begin
    first_src = 2'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (flagged[i]) begin
        first_src = chan_idx_t'(i);
      end
    end
  end

  // One formula serves both modes: single mode has a one-hot active set
  assign seen_nxt = seen_r | (conv_done_i & act);
  assign rdy_ev = (act != 4'h0) && ((seen_nxt & act) == act); // [R7]

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seen_r <= 4'h0;
    end else begin
      seen_r <= rdy_ev ? 4'h0 : (seen_nxt & act);
    end
  end

  // ---------------------------------------------------------------
  // Status flags, set beats a same-cycle clear
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      watchdog_timeout_flag_r <= 1'b0;
      amplitude_high_flag_r <= 1'b0;
      amplitude_low_flag_r <= 1'b0;
    end else begin
      watchdog_timeout_flag_r <= (|wd_ev) | (watchdog_timeout_flag_r & ~err_clear); // [R3] [R2]
      amplitude_high_flag_r <= (|ah_ev) | (amplitude_high_flag_r & ~err_clear); // [R5] [R4]
      amplitude_low_flag_r <= (|al_ev) | (amplitude_low_flag_r & ~err_clear); // [R6] [R4]
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_source_channel_r <= 2'h0;
    end else if ((|flagged) && (!err_latched || err_clear)) begin
      fault_source_channel_r <= first_src; // [R1]
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_ready_flag_r <= 1'b0;
    end else begin
      result_ready_flag_r <= (rdy_ev & result_ready_to_irq_en) // [R13] [R7]
                             | (result_ready_flag_r & ~status_rd);
    end
  end

  // ---------------------------------------------------------------
  // Interrupt pin
  // ---------------------------------------------------------------
  assign irq_pend_nxt = (rdy_ev & result_ready_to_irq_en) | (|wd_ev) // [R12] [R13]
                        | (irq_pend_r & ~status_rd); // [R17]

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_pend_r <= 1'b0;
      irq_pin_n_o <= 1'b1;
    end else begin
      irq_pend_r <= irq_pend_nxt;
      irq_pin_n_o <= ~(irq_pend_nxt & ~irq_pin_disable_i); // [R15]
    end
  end

  // ---------------------------------------------------------------
  // Per-channel trackers
  // ---------------------------------------------------------------
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
    chan_event_tracker u_trk (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .active_i(act[c]),
      .conv_done_i(conv_done_i[c]),
      .wd_i(wd_timeout_i[c]),
      .ah_i(amp_high_i[c]),
      .al_i(amp_low_i[c]),
      .wd_en_i(watchdog_to_result_en),
      .ah_en_i(amp_high_to_result_en),
      .al_en_i(amp_low_to_result_en),
      .data_read_i(data_rd[c]),
      .pending_o(pending_vec[c]),
      .wd_field_o(result_watchdog_field_o[c]),
      .amp_field_o(result_amplitude_field_o[c])
    );
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [15:0] status_word;
  always_comb begin
    status_word = `ST_RESET;
    status_word[`ST_SRC_HI:`ST_SRC_LO] = fault_source_channel_r; // [R1]
    status_word[`ST_WD_BIT] = watchdog_timeout_flag_r;
    status_word[`ST_AH_BIT] = amplitude_high_flag_r;
    status_word[`ST_AL_BIT] = amplitude_low_flag_r;
    status_word[`ST_RDY_BIT] = result_ready_flag_r;
    status_word[3:0] = {pending_vec[0], pending_vec[1], pending_vec[2], pending_vec[3]}; // [R8]
  end

  // Result registers themselves live outside; their reads only return zero here
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (status_rd) begin
        reg_rdata_o <= status_word;
      end else if (reg_rd_i && (reg_addr_i == `OFS_EVENT_ROUTING)) begin
        reg_rdata_o <= event_routing_config_r;
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_wd_seen;
    (|(wd_timeout_i & act)) && watchdog_to_irq_en;
  endsequence
  sequence s_wd_reported;
    ##1 watchdog_timeout_flag_r && irq_pend_r;
  endsequence

  property p_wd_sets;
    @(posedge sys_clk_i) disable iff (!resetn_i) s_wd_seen |-> s_wd_reported;
  endproperty
  a_wd_sets: assert property (p_wd_sets) else $error("watchdog flag or irq not set"); // [R3] [R12]

  property p_wd_gated;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (!watchdog_to_irq_en && !watchdog_timeout_flag_r && !(|ah_ev) && !(|al_ev)) |=> !watchdog_timeout_flag_r;
  endproperty
  a_wd_gated: assert property (p_wd_gated) else $error("watchdog flag set while gated"); // [R12]

  property p_err_hold;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (amplitude_high_flag_r && !err_clear) |=> amplitude_high_flag_r && $stable(fault_source_channel_r);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("latched error lost"); // [R2]

  property p_status_clr;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (status_rd && !(|flagged)) |=> !amplitude_low_flag_r && !amplitude_high_flag_r && !watchdog_timeout_flag_r;
  endproperty
  a_status_clr: assert property (p_status_clr) else $error("status read did not clear"); // [R4]

  property p_src;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (!err_latched && flagged == 4'h4) |=> fault_source_channel_r == 2'h2;
  endproperty
  a_src: assert property (p_src) else $error("wrong source channel"); // [R1]

  property p_irq_disable;
    @(posedge sys_clk_i) disable iff (!resetn_i) irq_pin_disable_i |=> irq_pin_n_o;
  endproperty
  a_irq_disable: assert property (p_irq_disable) else $error("pin asserted while disabled"); // [R15]

  property p_irq_release;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (status_rd && !rdy_ev && !(|wd_ev)) |=> irq_pin_n_o && !irq_pend_r;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("pin held after status read"); // [R17]

  property p_rdy;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (rdy_ev && result_ready_to_irq_en) |=> result_ready_flag_r && irq_pend_r;
  endproperty
  a_rdy: assert property (p_rdy) else $error("result ready not reported"); // [R7] [R13]

  property p_pending;
    @(posedge sys_clk_i) disable iff (!resetn_i)
      (conv_done_i[0] && act[0]) |=> status_word[3] [*1] ##0 pending_vec[0];
  endproperty
  a_pending: assert property (p_pending) else $error("channel 0 pending bit missing"); // [R8]

  property p_rsv;
    @(posedge sys_clk_i) disable iff (!resetn_i) (event_routing_config_r & ~`RT_WRITE_MASK) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved routing bits stored"); // [R14]

endmodule : sensor_status_error_reporting
`default_nettype wire

//--- tb/host_model.sv
// Host controller model: issues single register reads and writes.
// Assumes the block answers a read with a one-cycle valid pulse.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic rd_o,
  output logic wr_o,
  output logic [15:0] wdata_o,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i
);
  initial begin
    addr_o = 8'h00;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wdata_o = 16'h0000;
  end

  // ----------------------------------------
  // Accesses
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= (a == 8'h19) ? (d & ~16'h07C0) : d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Stale data would hide a late sample
    wdata_o <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    while (rvalid_i !== 1'b1 && n < 4) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    // Missing answer returns unknowns so the compare counts it
    d = (rvalid_i === 1'b1) ? rdata_i : 16'hXXXX;
  endtask : rd
endmodule : host_model
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking bench for the status and event routing block.
// Assumes host_model drives the register port; events are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sensor_status_pkg::*;
;
  logic sys_clk;
  logic resetn;
  logic [7:0] addr;
  logic rd, wr, rvalid, scan, dis, pin;
  logic [15:0] wdata, rdata, v;
  logic [1:0] act;
  chan_vec_t done, wdt, ahi, alo, mask, wf_o, af_o;
  int n_errors, n_compared, seed, ch;
  // Reference model state
  int st_wd, st_ah, st_al, st_rdy, src, irq;
  logic [15:0] m_route;
  chan_vec_t m_pend, m_wf, m_af, m_prog;

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  sensor_status_error_reporting #(.NUM_CHAN(4)) u_dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .conv_done_i(done),
    .wd_timeout_i(wdt), .amp_high_i(ahi), .amp_low_i(alo), .sequence_scan_enable_i(scan),
    .active_chan_i(act), .scan_chan_mask_i(mask), .irq_pin_disable_i(dis),
    .result_watchdog_field_o(wf_o), .result_amplitude_field_o(af_o), .irq_pin_n_o(pin));

  host_model u_host (.clk_i(sys_clk), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata),
    .rdata_i(rdata), .rvalid_i(rvalid));

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic cmp_word(input string what, input logic [15:0] e, input logic [15:0] g,
                          input logic [15:0] care);
    n_compared++;
    if ((g & care) !== (e & care)) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask : cmp_word

  task automatic cmp_bits(input string what, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b, seen %b", what, e, g);
    end
  endtask : cmp_bits

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Model and drivers
  // ----------------------------------------
  function automatic logic [15:0] m_status();
    logic [15:0] s;
    s = 16'h0000;
    s[15:14] = src[1:0];
    s[11] = st_wd[0];
    s[10] = st_ah[0];
    s[9] = st_al[0];
    s[6] = st_rdy[0];
    for (int c = 0; c < 4; c++) s[3 - c] = m_pend[c];
    return s;
  endfunction : m_status

  task automatic check_outs();
    cmp_bits("irq_pin_n", {3'b000, !(irq != 0 && !dis)}, {3'b000, pin});
    cmp_bits("result_watchdog_field", m_wf, wf_o);
    cmp_bits("result_amplitude_field", m_af, af_o);
  endtask : check_outs

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e, input logic [15:0] care);
    logic [15:0] d;
    u_host.rd(a, d);
    cmp_word($sformatf("register %h", a), e, d, care);
  endtask : rd_reg

  task automatic rd_status();
    // Source field means nothing while no error is latched
    rd_reg(8'h18, m_status(), (st_wd | st_ah | st_al) != 0 ? 16'hFFFF : 16'h3FFF);
    st_wd = 0;
    st_ah = 0;
    st_al = 0;
    st_rdy = 0;
    irq = 0;
    check_outs();
  endtask : rd_status

  task automatic rd_result(input int c);
    rd_reg(8'(2 * c), 16'h0000, 16'hFFFF);
    m_pend[c] = 1'b0;
    m_wf[c] = 1'b0;
    m_af[c] = 1'b0;
    if (src == c) begin
      st_wd = 0;
      st_ah = 0;
      st_al = 0;
    end
    @(posedge sys_clk);
    #1;
    check_outs();
  endtask : rd_result

  task automatic wr_route(input logic [15:0] r);
    u_host.wr(8'h19, r | (16'hC7DE & 16'($random(seed))));
    m_route = r & 16'h3821;
  endtask : wr_route

  task automatic cfg(input logic s, input chan_vec_t m, input logic [1:0] a, input logic d);
    @(posedge sys_clk);
    scan <= s;
    mask <= m;
    act <= a;
    dis <= d;
    #1;
  endtask : cfg

  // Kind 0 result, 1 watchdog, 2 amplitude high, 3 amplitude low
  task automatic ev(input int k, input int c);
    chan_vec_t set;
    set = scan ? mask : chan_vec_t'(4'h1 << act);
    @(posedge sys_clk);
    case (k)
      0: done[c] <= 1'b1;
      1: wdt[c] <= 1'b1;
      2: ahi[c] <= 1'b1;
      default: alo[c] <= 1'b1;
    endcase
    @(posedge sys_clk);
    done <= 4'h0;
    wdt <= 4'h0;
    ahi <= 4'h0;
    alo <= 4'h0;
    if (set[c] && k == 0) begin
      m_pend[c] = 1'b1;
      m_prog[c] = m_route[0];
      if (m_route[0] && (m_prog & set) == set) begin
        st_rdy = 1;
        irq = 1;
        m_prog = 4'h0;
      end
    end else if (set[c]) begin
      if ((k != 1 || m_route[5]) && st_wd + st_ah + st_al == 0) src = c;
      if (k == 1 && m_route[13]) m_wf[c] = 1'b1;
      if (k == 1 && m_route[5]) begin
        st_wd = 1;
        irq = 1;
      end
      if (k == 2) st_ah = 1;
      if (k == 3) st_al = 1;
      if ((k == 2 && m_route[12]) || (k == 3 && m_route[11])) m_af[c] = 1'b1;
    end
    #1;
    check_outs();
  endtask : ev

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #40000;
    n_errors++;
    $display("unexpected run length: expected end of tests, seen none");
    finish_test();
  end

  initial begin
    seed = 66185;
    {n_errors, n_compared, st_wd, st_ah, st_al, st_rdy, src, irq} = '0;
    {m_route, m_pend, m_wf, m_af, m_prog} = '0;
    {resetn, done, wdt, ahi, alo, scan, dis, act, mask} = '0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    check_outs();
    rd_status();
    rd_reg(8'h19, 16'h0000, 16'hFFFF);
    u_host.wr(8'h18, 16'hFFFF);
    rd_reg(8'h3C, 16'h0000, 16'hFFFF);
    rd_status();
    v = 16'($random(seed)) & 16'h3821;
    wr_route(v);
    rd_reg(8'h19, m_route, 16'hFFFF);
    $display("test reset_and_routing done");
    wr_route(16'h2020);
    for (int c = 0; c < 4; c++) begin
      cfg(1'b0, 4'h0, c[1:0], 1'b0);
      ev(1, c);
      rd_status();
      rd_status();
      rd_result(c);
    end
    wr_route(16'h0000);
    ch = $random(seed) & 3;
    cfg(1'b0, 4'h0, ch[1:0], 1'b0);
    ev(1, ch);
    rd_status();
    $display("test watchdog done");
    cfg(1'b1, 4'hF, 2'b00, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr_route(i != 0 ? 16'h0800 : 16'h1000);
      ev(2, 1);
      ev(3, 2);
      rd_result(2);
      rd_status();
      rd_result(1);
    end
    wr_route(16'h0000);
    ev(3, 3);
    rd_result(3);
    rd_status();
    $display("test amplitude done");
    wr_route(16'h0001);
    cfg(1'b1, 4'b1011, 2'b00, 1'b0);
    ev(0, 0);
    ev(0, 1);
    ev(0, 2);
    ev(0, 3);
    rd_status();
    rd_result(0);
    rd_status();
    cfg(1'b0, 4'h0, 2'b01, 1'b0);
    ev(0, 1);
    rd_status();
    wr_route(16'h0000);
    cfg(1'b0, 4'h0, 2'b00, 1'b0);
    ev(0, 0);
    rd_status();
    $display("test result_ready done");
    wr_route(16'h0020);
    cfg(1'b0, 4'h0, 2'b10, 1'b1);
    ev(1, 2);
    // Pending event must reach the pin once the disable drops
    cfg(1'b0, 4'h0, 2'b10, 1'b0);
    @(posedge sys_clk);
    #1;
    check_outs();
    rd_status();
    $display("test pin_disable done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
